// File: logic/rtc_pm_pkg.sv
// constants, field layout and types of the rtc power control slice
package rtc_pm_pkg;

  localparam int DATA_W = 32;
  localparam int ADDR_W = 16;
  localparam int REG_W = 16;

  // register index counts words, the bus byte address is four times it
  localparam logic [ADDR_W-1:0] PM_REG_INDEX = 16'h1930;
  localparam logic [ADDR_W-1:0] PM_REG_ADDR = {PM_REG_INDEX[13:0], 2'b00};

  localparam int BIT_CLK_OUT = 0;
  localparam int BIT_REG_PD = 1;
  localparam int BIT_REF_PD = 2;
  localparam int BIT_WAKE_DIR = 3;
  localparam int BIT_WAKE_DOUT = 4;
  localparam int BYTE_W = 8;

  // clock and system reset pulse timing
  localparam int CLK_MHZ = 125;
  localparam int SYS_RESET_NS = 64;
  localparam int RST_CYC = (SYS_RESET_NS * CLK_MHZ + 999) / 1000;
  localparam int RST_CNT_W = $clog2(RST_CYC);
  localparam logic [RST_CNT_W-1:0] RST_CNT_LAST = RST_CNT_W'(RST_CYC - 1);
  localparam logic [RST_CNT_W-1:0] RST_CNT_ONE = 3'h1;
  localparam logic [RST_CNT_W-1:0] RST_CNT_ZERO = 3'h0;

  typedef struct packed {
    logic wake_dout;
    logic wake_dir;
    logic reference_power_down;
    logic regulator_power_down;
    logic rtc_clock_out_enable;
  } pm_ctrl_s;

  localparam pm_ctrl_s CTRL_RESET = '{
    wake_dout: 1'b1,
    wake_dir: 1'b0,
    reference_power_down: 1'b0,
    regulator_power_down: 1'b0,
    rtc_clock_out_enable: 1'b0
  };

  typedef enum logic [1:0] {
    ST_ACTIVE,
    ST_DOWN,
    ST_RAMP,
    ST_RELEASE
  } pm_state_e;

endpackage : rtc_pm_pkg

// File: logic/pin_sync.sv
// three-stage synchroniser with agreement filter for one pin level
`timescale 1ns/1ps
module pin_sync (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic d,
  output logic q
);

  logic s1_r;
  logic s2_r;
  logic s3_r;
  logic q_r;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s1_r <= 1'b0;
      s2_r <= 1'b0;
      s3_r <= 1'b0;
    end else begin
      s1_r <= d;
      s2_r <= s1_r;
      s3_r <= s2_r;
    end
  end

  // only a level seen by both late stages is passed on
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q_r <= 1'b0;
    end else if (s2_r == s3_r) begin
      q_r <= s3_r;
    end
  end

  assign q = q_r;

endmodule : pin_sync

// File: logic/rtc_power_mgmt_control.sv
// rtc power management control: register, power-down sequencer, clock gate
//
// Our own choice: the APB slave port.
`timescale 1ns/1ps
// Operation
// - regulator power-down bit one shuts regulators and analog reset off
// - wake pin high (only while wake_dir is zero) or rtc alarm re-enables regulators and analog reset
// - regulator-only power-down leaves the bandgap reference running
// - bit zero gates the rtc clock output, one enables it
// - control register decoded at word index 1930h of rtc space
// - any power-down cuts core regulator, holds supply-valid low, isolates
// - reference power-down bit also shuts the bandgap reference off
// - supply threshold reached: supply-valid, system reset, isolation off
module rtc_power_mgmt_control (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [rtc_pm_pkg::ADDR_W-1:0] paddr,
  input wire logic [rtc_pm_pkg::DATA_W-1:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [rtc_pm_pkg::DATA_W-1:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic rtc_clk_in,
  input wire logic wake_in,
  output logic wake_out,
  output logic wake_oe_n,
  input wire logic alarm_irq,
  input wire logic supply_threshold,
  output logic rtc_clock_out,
  output logic regulator_enable,
  output logic power_on_reset_enable,
  output logic reference_enable,
  output logic core_regulator_output,
  output logic supply_valid,
  output logic system_reset_n,
  output logic rtc_isolate
);

  function automatic logic [rtc_pm_pkg::DATA_W-1:0] word_of(
    input rtc_pm_pkg::pm_ctrl_s c
  );
    logic [rtc_pm_pkg::DATA_W-1:0] w;
    w = '0;
    w[rtc_pm_pkg::BIT_CLK_OUT] = c.rtc_clock_out_enable;
    w[rtc_pm_pkg::BIT_REG_PD] = c.regulator_power_down;
    w[rtc_pm_pkg::BIT_REF_PD] = c.reference_power_down;
    w[rtc_pm_pkg::BIT_WAKE_DIR] = c.wake_dir;
    w[rtc_pm_pkg::BIT_WAKE_DOUT] = c.wake_dout;
    return w;
  endfunction : word_of

  // all live bits sit in the low byte lane; reserved bits ignore writes
  function automatic rtc_pm_pkg::pm_ctrl_s ctrl_of(
    input logic [rtc_pm_pkg::DATA_W-1:0] w,
    input logic lane0,
    input rtc_pm_pkg::pm_ctrl_s old
  );
    rtc_pm_pkg::pm_ctrl_s c;
    c = old;
    if (lane0) begin
      c.rtc_clock_out_enable = w[rtc_pm_pkg::BIT_CLK_OUT];
      c.regulator_power_down = w[rtc_pm_pkg::BIT_REG_PD];
      c.reference_power_down = w[rtc_pm_pkg::BIT_REF_PD];
      c.wake_dir = w[rtc_pm_pkg::BIT_WAKE_DIR];
      c.wake_dout = w[rtc_pm_pkg::BIT_WAKE_DOUT];
    end
    return c;
  endfunction : ctrl_of

  function automatic logic pd_request(input rtc_pm_pkg::pm_ctrl_s c);
    return c.regulator_power_down | c.reference_power_down;
  endfunction : pd_request

  rtc_pm_pkg::pm_ctrl_s ctrl_r;
  rtc_pm_pkg::pm_state_e st_r;
  rtc_pm_pkg::pm_state_e st_nxt;
  logic [rtc_pm_pkg::RST_CNT_W-1:0] cnt_r;
  logic [rtc_pm_pkg::DATA_W-1:0] prdata_r;
  logic pready_r;
  logic pslverr_r;
  logic rtc_clock_out_r;
  logic regulator_en_r;
  logic por_en_r;
  logic reference_en_r;
  logic core_reg_out_r;
  logic supply_valid_r;
  logic sys_reset_n_r;
  logic rtc_isolate_r;
  logic wake_out_r;
  logic wake_oe_n_r;
  logic wake_q;
  logic thr_q;
  logic rtc_clk_q;
  logic acc_first;
  logic acc_done;
  logic addr_hit;
  logic wake_evt;

  pin_sync u_wake_sync (
    .pclk(pclk),
    .presetn(presetn),
    .d(wake_in),
    .q(wake_q)
  );

  pin_sync u_thr_sync (
    .pclk(pclk),
    .presetn(presetn),
    .d(supply_threshold),
    .q(thr_q)
  );

  pin_sync u_clk_sync (
    .pclk(pclk),
    .presetn(presetn),
    .d(rtc_clk_in),
    .q(rtc_clk_q)
  );

  assign acc_first = psel & penable & ~pready_r;
  assign acc_done = psel & penable & pready_r;
  assign addr_hit = (paddr == rtc_pm_pkg::PM_REG_ADDR);
  // a wake pulse shorter than two pclk cycles may be lost in the filter
  assign wake_evt = (~ctrl_r.wake_dir & wake_q) | alarm_irq;

  // one wait state: pready rises in the second access cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_r <= 1'b0;
    end else begin
      pready_r <= acc_first;
    end
  end

  // accesses while supply-valid is low and unmapped addresses answer with an error
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pslverr_r <= 1'b0;
      prdata_r <= '0;
    end else if (acc_first) begin
      pslverr_r <= ~addr_hit | ~supply_valid_r;
      if (!pwrite && addr_hit && supply_valid_r) begin
        prdata_r <= word_of(ctrl_r);
      end else begin
        prdata_r <= '0;
      end
    end else begin
      pslverr_r <= 1'b0;
    end
  end

  // power-down bits drop by hardware on wake; bus is closed then
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_r <= rtc_pm_pkg::CTRL_RESET;
    end else if (st_r == rtc_pm_pkg::ST_DOWN && wake_evt) begin
      ctrl_r.regulator_power_down <= 1'b0;
      ctrl_r.reference_power_down <= 1'b0;
    end else if (acc_done && pwrite && !pslverr_r) begin
      ctrl_r <= ctrl_of(pwdata, pstrb[0], ctrl_r);
    end
  end

  always_comb begin
    st_nxt = st_r;
    case (st_r)
      rtc_pm_pkg::ST_ACTIVE: begin
        if (pd_request(ctrl_r)) begin
          st_nxt = rtc_pm_pkg::ST_DOWN;
        end
      end
      rtc_pm_pkg::ST_DOWN: begin
        if (wake_evt) begin
          st_nxt = rtc_pm_pkg::ST_RAMP;
        end
      end
      rtc_pm_pkg::ST_RAMP: begin
        if (thr_q) begin
          st_nxt = rtc_pm_pkg::ST_RELEASE;
        end
      end
      rtc_pm_pkg::ST_RELEASE: begin
        if (cnt_r == rtc_pm_pkg::RST_CNT_LAST) begin
          st_nxt = rtc_pm_pkg::ST_ACTIVE;
        end
      end
      default: begin
        st_nxt = rtc_pm_pkg::ST_ACTIVE;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r <= rtc_pm_pkg::ST_ACTIVE;
    end else begin
      st_r <= st_nxt;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_r <= rtc_pm_pkg::RST_CNT_ZERO;
    end else if (st_r == rtc_pm_pkg::ST_RELEASE) begin
      cnt_r <= cnt_r + rtc_pm_pkg::RST_CNT_ONE;
    end else begin
      cnt_r <= rtc_pm_pkg::RST_CNT_ZERO;
    end
  end

  // supply controls follow the next state so they change with it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      regulator_en_r <= 1'b1;
      por_en_r <= 1'b1;
      core_reg_out_r <= 1'b1;
      reference_en_r <= 1'b1;
    end else begin
      regulator_en_r <= st_nxt != rtc_pm_pkg::ST_DOWN;
      por_en_r <= st_nxt != rtc_pm_pkg::ST_DOWN;
      core_reg_out_r <= st_nxt != rtc_pm_pkg::ST_DOWN;
      // bandgap kept alive for a quick wake unless asked off
      reference_en_r <= !(st_nxt == rtc_pm_pkg::ST_DOWN &&
                          ctrl_r.reference_power_down);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      supply_valid_r <= 1'b1;
      sys_reset_n_r <= 1'b1;
      rtc_isolate_r <= 1'b0;
    end else begin
      supply_valid_r <= st_nxt == rtc_pm_pkg::ST_RELEASE ||
                        st_nxt == rtc_pm_pkg::ST_ACTIVE;
      sys_reset_n_r <= st_nxt != rtc_pm_pkg::ST_RELEASE;
      rtc_isolate_r <= st_nxt != rtc_pm_pkg::ST_ACTIVE;
    end
  end

  // gated copy of the sampled rtc clock, low whenever disabled
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rtc_clock_out_r <= 1'b0;
    end else begin
      rtc_clock_out_r <= ctrl_r.rtc_clock_out_enable & rtc_clk_q;
    end
  end

  // open-drain wake pin: only ever pulls low
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wake_out_r <= 1'b0;
      wake_oe_n_r <= 1'b1;
    end else begin
      wake_out_r <= 1'b0;
      wake_oe_n_r <= ~(ctrl_r.wake_dir & ~ctrl_r.wake_dout);
    end
  end

  assign prdata = prdata_r;
  assign pready = pready_r;
  assign pslverr = pslverr_r;
  assign rtc_clock_out = rtc_clock_out_r;
  assign regulator_enable = regulator_en_r;
  assign power_on_reset_enable = por_en_r;
  assign reference_enable = reference_en_r;
  assign core_regulator_output = core_reg_out_r;
  assign supply_valid = supply_valid_r;
  assign system_reset_n = sys_reset_n_r;
  assign rtc_isolate = rtc_isolate_r;
  assign wake_out = wake_out_r;
  assign wake_oe_n = wake_oe_n_r;

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  AST_PD_CUTS_SUPPLY: assert property (
    (st_r == rtc_pm_pkg::ST_ACTIVE && ctrl_r.regulator_power_down)
    |=> (!regulator_en_r && !por_en_r))
    else $error("regulator power-down did not cut regulators");

  AST_WAKE_RESTORES: assert property (
    (st_r == rtc_pm_pkg::ST_DOWN && wake_evt)
    |=> (regulator_en_r && por_en_r && !ctrl_r.regulator_power_down))
    else $error("wake did not re-enable regulators");

  AST_BANDGAP_KEPT: assert property (
    (st_r == rtc_pm_pkg::ST_DOWN && !ctrl_r.reference_power_down)
    |-> reference_en_r)
    else $error("bandgap dropped in regulator-only power-down");

  AST_CLKOUT_GATE: assert property (
    !ctrl_r.rtc_clock_out_enable |=> !rtc_clock_out_r)
    else $error("rtc clock output not gated off");

  AST_CLKOUT_PASS: assert property (
    (ctrl_r.rtc_clock_out_enable && rtc_clk_q) |=> rtc_clock_out_r)
    else $error("enabled rtc clock output not passed");

  AST_REG_WRITE: assert property (
    (acc_done && pwrite && addr_hit && !pslverr_r && pstrb[0] &&
     st_r == rtc_pm_pkg::ST_ACTIVE)
    |=> (word_of(ctrl_r) == ($past(pwdata) & 32'h0000001f)))
    else $error("register write at its address not stored");

  AST_UNMAPPED_ERR: assert property (
    (acc_first && !addr_hit) |=> (pready_r && pslverr_r && prdata_r == '0))
    else $error("unmapped access not answered with error");

  AST_ISOLATED: assert property (
    !core_reg_out_r |-> (!supply_valid_r && rtc_isolate_r))
    else $error("supply-valid high with core regulator off");

  AST_REF_PD: assert property (
    (st_r == rtc_pm_pkg::ST_ACTIVE && ctrl_r.reference_power_down)
    |=> (!reference_en_r ##0 !regulator_en_r))
    else $error("reference power-down did not cut bandgap");

  sequence thr_seen;
    st_r == rtc_pm_pkg::ST_RAMP && thr_q;
  endsequence

  sequence reset_pulse;
    (supply_valid_r && !sys_reset_n_r && rtc_isolate_r) [*8]
    ##1 (sys_reset_n_r && !rtc_isolate_r && supply_valid_r);
  endsequence

  AST_RELEASE_SEQ: assert property (
    thr_seen |=> reset_pulse)
    else $error("release sequence after threshold wrong");

endmodule : rtc_power_mgmt_control

// File: verification/rtc_power_mgmt_control_test.sv
// self-checking bench for the rtc power management control slice
`timescale 1ns/1ps
module rtc_power_mgmt_control_test;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [rtc_pm_pkg::ADDR_W-1:0] paddr = '0;
  logic [rtc_pm_pkg::DATA_W-1:0] pwdata = '0;
  logic [3:0] pstrb = 4'h0;
  logic [rtc_pm_pkg::DATA_W-1:0] prdata;
  logic pready, pslverr, wake_out, wake_oe_n, rtc_clock_out;
  logic regulator_enable, power_on_reset_enable, reference_enable;
  logic core_regulator_output, supply_valid, system_reset_n, rtc_isolate;
  logic rtc_clk_in = 1'b0;
  logic wake_in = 1'b0;
  logic alarm_irq = 1'b0;
  logic supply_threshold = 1'b0;
  logic [3:0] ck_cnt = 4'h0;
  logic [6:0] pwr;
  int n_mismatch = 0;
  int checks_done = 0;
  localparam logic [15:0] A = rtc_pm_pkg::PM_REG_ADDR;

  assign pwr = {regulator_enable, power_on_reset_enable, reference_enable,
    core_regulator_output, supply_valid, system_reset_n, rtc_isolate};

  always #4 pclk = ~pclk;

  // slow square wave, 16 pclk period, so the gated copy is countable
  always @(posedge pclk) begin
    ck_cnt <= ck_cnt + 4'h1;
    rtc_clk_in <= ck_cnt[3];
  end

  rtc_power_mgmt_control u_rtc_power_mgmt_control (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .rtc_clk_in(rtc_clk_in), .wake_in(wake_in), .wake_out(wake_out),
    .wake_oe_n(wake_oe_n), .alarm_irq(alarm_irq),
    .supply_threshold(supply_threshold), .rtc_clock_out(rtc_clock_out),
    .regulator_enable(regulator_enable),
    .power_on_reset_enable(power_on_reset_enable),
    .reference_enable(reference_enable),
    .core_regulator_output(core_regulator_output),
    .supply_valid(supply_valid), .system_reset_n(system_reset_n),
    .rtc_isolate(rtc_isolate)
  );

  task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  task end_of_test;
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : end_of_test

  // request held until pready is sampled high at a rising edge
  task apb(input logic is_wr, input logic [15:0] a, input logic [31:0] d,
           input logic [3:0] st, output logic [31:0] rdata, output logic err);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= is_wr;
    paddr <= a;
    pwdata <= d;
    pstrb <= st;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) chk("pready", 32'h1, 32'h0);
    rdata = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task wr(input logic [15:0] a, input logic [31:0] d, input logic [3:0] st,
          input logic e);
    logic [31:0] r;
    logic x;
    apb(1'b1, a, d, st, r, x);
    chk("write pslverr", {31'h0, e}, {31'h0, x});
  endtask : wr

  task rd(input logic [15:0] a, input logic [31:0] exp, input logic e);
    logic [31:0] r;
    logic x;
    apb(1'b0, a, 32'h0, 4'h0, r, x);
    chk("read pslverr", {31'h0, e}, {31'h0, x});
    chk("prdata", exp, r);
  endtask : rd

  task clk_cnt(input logic [31:0] exp);
    int h;
    h = 0;
    repeat (8) @(negedge pclk);
    repeat (32) begin
      @(negedge pclk);
      if (rtc_clock_out === 1'b1) h++;
    end
    chk("rtc_clock_out highs", exp, 32'(h));
  endtask : clk_cnt

  // called right after the write edge: outputs fall one edge later
  task off_chk(input logic [6:0] exp);
    @(negedge pclk);
    chk("power state before", 32'h7e, {25'h0, pwr});
    @(negedge pclk);
    chk("power state down", {25'h0, exp}, {25'h0, pwr});
  endtask : off_chk

  task wake_chk;
    int n;
    n = 0;
    while (regulator_enable !== 1'b1 && n < 40) begin
      @(negedge pclk);
      n++;
    end
    chk("power state ramp", 32'h7b, {25'h0, pwr});
  endtask : wake_chk

  task release_chk;
    int n;
    n = 0;
    while (supply_valid !== 1'b1 && n < 40) begin
      @(negedge pclk);
      n++;
    end
    chk("isolate in reset", 32'h1, {31'h0, rtc_isolate});
    n = 0;
    while (system_reset_n === 1'b0 && n < 20) begin
      @(negedge pclk);
      n++;
    end
    chk("system reset cycles", 32'(rtc_pm_pkg::RST_CYC), 32'(n));
    chk("power state active", 32'h7e, {25'h0, pwr});
  endtask : release_chk

  initial begin
    repeat (5000) @(posedge pclk);
    n_mismatch++;
    end_of_test();
  end

  initial begin
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    @(negedge pclk);
    chk("power state reset", 32'h7e, {25'h0, pwr});
    chk("wake_oe_n reset", 32'h1, {31'h0, wake_oe_n});
    rd(A, 32'h10, 1'b0);
    rd(A + 16'h4, 32'h0, 1'b1);
    wr(A, 32'hffffffe1, 4'hf, 1'b0);
    rd(A, 32'h1, 1'b0);
    wr(A, 32'h11, 4'he, 1'b0);
    rd(A, 32'h1, 1'b0);
    $display("test registers done");
    clk_cnt(32'h10);
    wr(A, 32'h10, 4'hf, 1'b0);
    clk_cnt(32'h0);
    $display("test clock gate done");
    // internal regulators assumed to supply the chip here
    wr(A, 32'h12, 4'hf, 1'b0);
    off_chk(7'h13);
    rd(A, 32'h0, 1'b1);
    wr(A, 32'h01, 4'hf, 1'b1);
    @(posedge pclk);
    wake_in <= 1'b1;
    // bench rtc clock period is 16 pclk
    repeat (16) @(posedge pclk);
    wake_in <= 1'b0;
    wake_chk();
    repeat (10) @(negedge pclk);
    chk("held before threshold", 32'h0, {31'h0, supply_valid});
    @(posedge pclk);
    supply_threshold <= 1'b1;
    release_chk();
    rd(A, 32'h10, 1'b0);
    $display("test regulator wake done");
    wr(A, 32'h08, 4'hf, 1'b0);
    repeat (2) @(negedge pclk);
    chk("wake_oe_n driving", 32'h0, {31'h0, wake_oe_n});
    chk("wake_out", 32'h0, {31'h0, wake_out});
    wr(A, 32'h0c, 4'hf, 1'b0);
    off_chk(7'h03);
    @(posedge pclk);
    wake_in <= 1'b1;
    repeat (6) @(posedge pclk);
    wake_in <= 1'b0;
    repeat (10) @(negedge pclk);
    chk("pin ignored as output", 32'h03, {25'h0, pwr});
    @(posedge pclk);
    alarm_irq <= 1'b1;
    @(posedge pclk);
    alarm_irq <= 1'b0;
    wake_chk();
    release_chk();
    rd(A, 32'h08, 1'b0);
    $display("test reference and alarm wake done");
    end_of_test();
  end
endmodule : rtc_power_mgmt_control_test
